// >>> rtl/enfc_fifo.sv
// small synchronous valid/ready fifo
`timescale 1ns/10ps
module enfc_fifo #(
   parameter int W = 258,
   parameter int D = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   // count is one bit wider than the pointers so a full fifo is visible
   assign in_ready_out = (cnt_q != (AW+1)'(D));
   assign out_valid_out = (cnt_q != '0);
   assign out_data_out = mem_q[rd_q];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // enfc_fifo

// >>> rtl/enfc_link_if.sv
// link between user design and network access point
`timescale 1ns/10ps
interface enfc_link_if #(parameter int W = 256);
   logic tx_valid;
   logic tx_ready;
   logic [W-1:0] tx_data;
   logic tx_sop;
   logic tx_eop;
   logic rx_valid;
   logic rx_ready;
   logic [W-1:0] rx_data;
   logic rx_sop;
   logic rx_eop;
   logic [1:0] mac_id;
   logic [4:0] lane;
   modport dev (input tx_valid, tx_data, tx_sop, tx_eop, rx_ready,
      output tx_ready, rx_valid, rx_data, rx_sop, rx_eop, mac_id, lane);
   modport usr (output tx_valid, tx_data, tx_sop, tx_eop, rx_ready,
      input tx_ready, rx_valid, rx_data, rx_sop, rx_eop, mac_id, lane);
endinterface // enfc_link_if

// >>> rtl/enfc_map.svh
// constants for the access point flow control block
`ifndef ENFC_MAP_SVH
`define ENFC_MAP_SVH
`define ENFC_DATA_W 256
`define ENFC_LANE_W 5
`define ENFC_PRE_LO_A 5'h10
`define ENFC_PRE_HI_A 5'h13
`define ENFC_EXP_LO_A 5'h14
`define ENFC_EXP_HI_A 5'h17
`define ENFC_PRE_LO_B 5'h18
`define ENFC_PRE_HI_B 5'h1b
`define ENFC_EXP_LO_B 5'h1c
`define ENFC_EXP_HI_B 5'h1f
`define ENFC_WIN_CYC 4'hd
`define ENFC_WIN_CREDIT 4'ha
`define ENFC_FIFO_DEPTH 4
`define ENFC_MAC_IDX 2'h0
`define ENFC_MAC_Q0 2'h1
`define ENFC_MAC_Q1 2'h2
`endif

// >>> rtl/enfc_nap_end.sv
// access point end: lane map, tx gating, whole-packet rx delivery
// What the document requires of both ends
// RULE1: each quad channel has preemptable and express interface
// RULE2: express frames go ahead of preemptable frames
// RULE3: lanes 16-19, 24-27 map to preemptable channels
// RULE4: lanes 20-23, 28-31 map to express channels
// RULE5: user prefers express channel when using one
// RULE6: at 200/400G store whole packet, then forward; nap end also forwards a full PKT_WORDS buffer before eop
// RULE7: tx ready high when next packet/segment fits
// RULE8: high rate user gates transmit on tx ready
// RULE9: low rate user limits its transmit rate
// RULE10: duty cycle at most ten of thirteen
// RULE11: throttle between packets, long packets inside; user end throttles on any cycle once credit is spent
// RULE12: user accepts whole packet without dropping ready; user end drops ready whenever its rx fifo is full
// RULE13: once started, rx packet sent contiguously
// RULE14: user buffers rx in fifo, backpressure after
// RULE15: rx backpressure only between packets; user end backpressures whenever its rx fifo is full
// RULE16: signals grouped by mac identifier
// RULE17: shared clock runs at higher of rates
// RULE18: credit counter, ten per thirteen cycle window
`timescale 1ns/10ps
`include "enfc_map.svh"
module enfc_nap_end import enfc_pkg::*; #(
   parameter int W = `ENFC_DATA_W,
   parameter int PKT_WORDS = 8
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // configuration
   input wire logic [4:0] lane_in,
   input wire logic [1:0] rate_in,
   input wire logic mode_in,
   input wire logic [1:0] mac_id_in,
   // mac side transmit
   output logic mac_tx_valid_out,
   output logic [W-1:0] mac_tx_data_out,
   output logic mac_tx_eop_out,
   output logic mac_tx_express_out,
   input wire logic mac_tx_ready_in,
   // mac side receive
   input wire logic mac_rx_valid_in,
   input wire logic [W-1:0] mac_rx_data_in,
   input wire logic mac_rx_sop_in,
   input wire logic mac_rx_eop_in,
   // link
   enfc_link_if.dev link
);
   enfc_chan_t chan_q;
   logic store_q;
   logic [W+1:0] buf_q [PKT_WORDS];
   logic [$clog2(PKT_WORDS):0] fill_q;
   logic [$clog2(PKT_WORDS):0] drain_q;
   logic full_pkt_q;
   logic tx_ready_q;
   logic rx_active_q;
   logic [W-1:0] rx_data_q;
   logic rx_valid_q;
   logic rx_sop_q;
   logic rx_eop_q;
   logic [1:0] mac_id_q;
   logic [4:0] lane_q;
   logic mtx_v_q;
   logic [W-1:0] mtx_d_q;
   logic mtx_e_q;
   logic mtx_x_q;
   logic take;

   function automatic enfc_chan_t lane_chan(input logic [4:0] l);
      if ((l >= `ENFC_EXP_LO_A && l <= `ENFC_EXP_HI_A) ||
          (l >= `ENFC_EXP_LO_B && l <= `ENFC_EXP_HI_B)) begin
         return ENFC_EXPRESS; // [RULE4]
      end else begin
         return ENFC_PREEMPT; // [RULE3]
      end
   endfunction

   // lane picks the preemptable or the express channel [RULE1]
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         chan_q <= ENFC_PREEMPT;
         store_q <= 1'b0;
      end else begin
         chan_q <= lane_chan(lane_in);
         store_q <= (rate_in != 2'(ENFC_R100)); // [RULE6]
      end
   end

   // identity of this point, shown to the user end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         mac_id_q <= `ENFC_MAC_IDX;
         lane_q <= '0;
      end else begin
         mac_id_q <= mac_id_in; // [RULE16]
         lane_q <= lane_in;
      end
   end

   assign take = link.tx_valid & tx_ready_q;

   // store-and-forward buffer; transparent path otherwise
   always_ff @(posedge clk_in) begin
      if (take && store_q) begin
         buf_q[fill_q[$clog2(PKT_WORDS)-1:0]] <=
            {link.tx_eop, link.tx_sop, link.tx_data};
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         fill_q <= '0;
         drain_q <= '0;
         full_pkt_q <= 1'b0;
      end else if (store_q) begin
         if (!full_pkt_q && take) begin
            fill_q <= fill_q + 1'b1;
            // whole packet held, or buffer full, before forwarding [RULE6]
            if (link.tx_eop || fill_q == PKT_WORDS - 1) begin
               full_pkt_q <= 1'b1;
            end
         end
         if (full_pkt_q && mac_tx_ready_in) begin
            if (drain_q + 1'b1 == fill_q) begin
               drain_q <= '0;
               fill_q <= '0;
               full_pkt_q <= 1'b0;
            end else begin
               drain_q <= drain_q + 1'b1;
            end
         end
      end
   end

   // when storing, ready only when buffer can take the next word or segment; else registered mac ready [RULE7]
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         tx_ready_q <= 1'b0;
      end else if (store_q) begin
         tx_ready_q <= !full_pkt_q && !(take && link.tx_eop) &&
            (fill_q + (take ? 1'b1 : 1'b0) < PKT_WORDS);
      end else begin
         tx_ready_q <= mac_tx_ready_in;
      end
   end

   // express marked so the mac sends it ahead of preemptable [RULE2]
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         mtx_v_q <= 1'b0;
         mtx_d_q <= '0;
         mtx_e_q <= 1'b0;
         mtx_x_q <= 1'b0;
      end else if (store_q) begin
         mtx_v_q <= full_pkt_q && mac_tx_ready_in;
         mtx_d_q <= buf_q[drain_q[$clog2(PKT_WORDS)-1:0]][W-1:0];
         mtx_e_q <= buf_q[drain_q[$clog2(PKT_WORDS)-1:0]][W+1];
         mtx_x_q <= (chan_q == ENFC_EXPRESS);
      end else begin
         mtx_v_q <= take;
         mtx_d_q <= link.tx_data;
         mtx_e_q <= link.tx_eop;
         mtx_x_q <= (chan_q == ENFC_EXPRESS);
      end
   end

   // a refused start drops the whole packet, never just its head
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_active_q <= 1'b0;
      end else if (mac_rx_valid_in && mac_rx_sop_in) begin
         rx_active_q <= link.rx_ready && !mac_rx_eop_in;
      end else if (mac_rx_valid_in && mac_rx_eop_in) begin
         rx_active_q <= 1'b0;
      end
   end

   // receive: once a packet starts it flows every cycle [RULE13]
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rx_valid_q <= 1'b0;
         rx_data_q <= '0;
         rx_sop_q <= 1'b0;
         rx_eop_q <= 1'b0;
      end else begin
         if (mac_rx_sop_in) begin
            rx_valid_q <= mac_rx_valid_in && link.rx_ready;
         end else begin
            rx_valid_q <= mac_rx_valid_in && rx_active_q;
         end
         rx_data_q <= mac_rx_data_in;
         rx_sop_q <= mac_rx_sop_in;
         rx_eop_q <= mac_rx_eop_in;
      end
   end

   assign link.tx_ready = tx_ready_q;
   assign link.rx_valid = rx_valid_q;
   assign link.rx_data = rx_data_q;
   assign link.rx_sop = rx_sop_q;
   assign link.rx_eop = rx_eop_q;
   assign link.mac_id = mac_id_q;
   assign link.lane = lane_q;
   assign mac_tx_valid_out = mtx_v_q;
   assign mac_tx_data_out = mtx_d_q;
   assign mac_tx_eop_out = mtx_e_q;
   assign mac_tx_express_out = mtx_x_q;
endmodule // enfc_nap_end

// >>> rtl/enfc_pkg.sv
// types for the access point flow control block
package enfc_pkg;
   typedef enum logic [1:0] {ENFC_R100, ENFC_R200, ENFC_R400} enfc_rate_t;
   typedef enum logic {ENFC_PACKET, ENFC_QUAD_SEG} enfc_mode_t;
   typedef enum logic {ENFC_PREEMPT, ENFC_EXPRESS} enfc_chan_t;
endpackage

// >>> rtl/enfc_user_end.sv
// user end: tx rate limiter or ready gating, rx fifo
`timescale 1ns/10ps
`include "enfc_map.svh"
module enfc_user_end import enfc_pkg::*; #(
   parameter int W = `ENFC_DATA_W,
   parameter int DEPTH = `ENFC_FIFO_DEPTH,
   parameter logic [3:0] WIN = `ENFC_WIN_CYC,
   parameter logic [3:0] CREDIT = `ENFC_WIN_CREDIT
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // configuration
   input wire logic [1:0] rate_in,
   // user transmit source
   input wire logic src_valid_in,
   input wire logic [W-1:0] src_data_in,
   input wire logic src_sop_in,
   input wire logic src_eop_in,
   output logic src_ready_out,
   // user receive sink
   output logic snk_valid_out,
   output logic [W-1:0] snk_data_out,
   output logic snk_sop_out,
   output logic snk_eop_out,
   input wire logic snk_ready_in,
   // link
   enfc_link_if.usr link
);
   logic [3:0] win_q;
   logic [3:0] used_q;
   logic lim_ok;
   logic hi_rate;
   logic fire;
   logic fin_ready;
   logic fout_valid;
   logic [W+1:0] fout_data;
   logic snk_v_q;
   logic [W+1:0] snk_d_q;

   // limiter on at 100g and below; high rates gate on ready only [RULE8]
   assign hi_rate = (rate_in != 2'(ENFC_R100));
   assign lim_ok = hi_rate || (used_q < CREDIT); // [RULE9] [RULE10]
   assign fire = src_valid_in && lim_ok && link.tx_ready;
   assign link.tx_valid = src_valid_in && lim_ok; // [RULE11]
   assign link.tx_data = src_data_in;
   assign link.tx_sop = src_sop_in;
   assign link.tx_eop = src_eop_in;
   assign src_ready_out = lim_ok && link.tx_ready;

   // 13-cycle window allowing 10 transfer cycles [RULE18]
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         win_q <= '0;
         used_q <= '0;
      end else if (win_q == WIN - 1'b1) begin
         win_q <= '0;
         used_q <= '0;
      end else begin
         win_q <= win_q + 1'b1;
         used_q <= used_q + (fire ? 4'h1 : 4'h0);
      end
   end

   // rx fifo absorbs up to DEPTH words; backpressure on its output [RULE14]
   // ready is the fifo not-full flag, so it can drop inside a packet [RULE12] [RULE15]
   assign link.rx_ready = fin_ready;
   enfc_fifo #(.W(W + 2), .D(DEPTH)) u_rx_fifo (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .in_valid_in(link.rx_valid),
      .in_ready_out(fin_ready),
      .in_data_in({link.rx_eop, link.rx_sop, link.rx_data}),
      .out_valid_out(fout_valid),
      .out_ready_in(!snk_v_q || snk_ready_in),
      .out_data_out(fout_data)
   );

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         snk_v_q <= 1'b0;
         snk_d_q <= '0;
      end else if (!snk_v_q || snk_ready_in) begin
         snk_v_q <= fout_valid;
         snk_d_q <= fout_data;
      end
   end

   assign snk_valid_out = snk_v_q;
   assign snk_data_out = snk_d_q[W-1:0];
   assign snk_sop_out = snk_d_q[W];
   assign snk_eop_out = snk_d_q[W+1];
endmodule // enfc_user_end

// >>> testbench/enfc_link_assertions.sv
// checks on the link between the user end and the access point end
`timescale 1ns/10ps
module enfc_link_assertions (
   // clock, reset and rate
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [1:0] rate_in,
   // link signals
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic rx_sop,
   input wire logic rx_eop
);
   logic [25:0] hist_q;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // windows of 13 may abut, so any 26 cycles can legally hold 23 takes
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         hist_q <= '0;
      end else begin
         hist_q <= {hist_q[24:0], tx_valid & tx_ready};
      end
   end
   a_tx_rate_cap: assert property (
      rate_in == 2'h0 |-> $countones(hist_q) <= 23)
      else $error("low rate duty limit exceeded");
   a_tx_rst_quiet: assert property (!$past(rst_b_in) |-> !tx_ready)
      else $error("tx ready high right after reset");
   a_rx_rst_quiet: assert property (!$past(rst_b_in) |-> !rx_valid)
      else $error("rx valid high right after reset");
   a_rx_contig: assert property (
      rx_valid && !rx_eop |=> rx_valid)
      else $error("gap inside a receive packet");
   a_rx_boundary: assert property (
      rx_valid && rx_eop |=> !rx_valid || rx_sop)
      else $error("word after end is not a start");
   a_rx_no_resop: assert property (
      rx_valid && !rx_eop |=> !rx_sop)
      else $error("start flag inside a packet");
   a_rx_ready_held: assert property (
      rx_valid && rx_ready && !rx_eop |=> rx_ready)
      else $error("rx ready dropped inside a packet");
   a_rx_start_room: assert property (
      rx_valid && rx_sop |-> rx_ready)
      else $error("packet started with no room");
   c_low_take: cover property (rate_in == 2'h0 && tx_valid && tx_ready);
   c_rx_full: cover property (rx_ready ##1 !rx_ready);
   c_rx_long: cover property (rx_valid && rx_sop && !rx_eop ##1 rx_valid);
endmodule // enfc_link_assertions

// >>> testbench/tb_top.sv
// self-checking bench for both ends of the access point link
`timescale 1ns/10ps
module tb_top;
   localparam int W = 32;
   logic clk_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic [1:0] rate = 2'h0;
   logic [4:0] lane = 5'h10;
   logic [1:0] mac_id = 2'h2;
   logic mode = 1'b0;
   logic mtx_rdy = 1'b1;
   logic mtx_v, mtx_exp, mtx_eop, src_rdy, snk_v, snk_sop, snk_eop;
   bit eop_log [128];
   logic [W-1:0] mtx_d, snk_d;
   logic [W-1:0] mrx_d = '0;
   logic [W-1:0] src_d = '0;
   logic mrx_v = 1'b0, mrx_sop = 1'b0, mrx_eop = 1'b0;
   logic src_v = 1'b0, src_sop = 1'b0, src_eop = 1'b0, snk_rdy = 1'b0;
   int failures = 0, checks = 0, cyc = 0;
   int ntx = 0, nrx = 0, tx_next = 0, rx_len = 1;
   enfc_link_if #(.W(W)) link ();
   enfc_nap_end #(.W(W)) u_enfc_nap_end (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .lane_in(lane), .rate_in(rate), .mode_in(mode),
      .mac_id_in(mac_id), .mac_tx_valid_out(mtx_v), .mac_tx_data_out(mtx_d),
      .mac_tx_eop_out(mtx_eop), .mac_tx_express_out(mtx_exp),
      .mac_tx_ready_in(mtx_rdy), .mac_rx_valid_in(mrx_v),
      .mac_rx_data_in(mrx_d), .mac_rx_sop_in(mrx_sop),
      .mac_rx_eop_in(mrx_eop), .link(link));
   enfc_user_end #(.W(W)) u_enfc_user_end (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .rate_in(rate), .src_valid_in(src_v),
      .src_data_in(src_d), .src_sop_in(src_sop), .src_eop_in(src_eop),
      .src_ready_out(src_rdy), .snk_valid_out(snk_v), .snk_data_out(snk_d),
      .snk_sop_out(snk_sop), .snk_eop_out(snk_eop), .snk_ready_in(snk_rdy),
      .link(link));
   enfc_link_assertions u_enfc_link_assertions (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .rate_in(rate), .tx_valid(link.tx_valid),
      .tx_ready(link.tx_ready), .rx_valid(link.rx_valid),
      .rx_ready(link.rx_ready), .rx_sop(link.rx_sop), .rx_eop(link.rx_eop));
   always #20 clk_in = ~clk_in;
   task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      // the whole run needs well under a thousand cycles
      if (cyc == 3000) begin
         failures++;
         wrap_up();
      end
   end
   // words must leave each end in the order they went in
   always @(posedge clk_in) begin
      if (mtx_v === 1'b1 && mtx_rdy === 1'b1) begin
         chk(mtx_d, ntx);
         chk(32'(mtx_exp), 32'(lane[2]));
         chk(32'(mtx_eop), 32'(eop_log[ntx]));
         ntx++;
      end
      if (snk_v === 1'b1 && snk_rdy === 1'b1) begin
         chk(snk_d, nrx);
         chk(32'(snk_sop), 32'(nrx % rx_len == 0));
         chk(32'(snk_eop), 32'(nrx % rx_len == rx_len - 1));
         nrx++;
      end
   end
   task automatic do_reset(input logic [1:0] r);
      rst_b_in <= 1'b0;
      rate <= r;
      repeat (10) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_in);
   endtask
   // valid holds until the edge that sees ready
   task automatic send(input logic s, input logic e);
      int n;
      n = 0;
      src_v <= 1'b1;
      src_d <= tx_next;
      src_sop <= s;
      src_eop <= e;
      eop_log[tx_next] = e;
      tx_next++;
      do begin
         @(posedge clk_in);
         n++;
      end while (src_rdy !== 1'b1 && n < 300);
      chk(32'(n < 300), 1);
   endtask
   task automatic pkt(input int len);
      for (int i = 0; i < len; i++) begin
         send(i == 0, i == len - 1);
      end
      src_v <= 1'b0;
   endtask
   // the mac side has no ready, so a packet streams without a gap
   task automatic rxpkt(input int base, input int len);
      for (int i = 0; i < len; i++) begin
         mrx_v <= 1'b1;
         mrx_d <= base + i;
         mrx_sop <= (i == 0);
         mrx_eop <= (i == len - 1);
         @(posedge clk_in);
      end
   endtask
   task automatic s_lanes();
      for (int l = 16; l < 32; l++) begin
         lane <= 5'(l);
         @(posedge clk_in);
         pkt(1);
         repeat (4) @(posedge clk_in);
      end
      chk(ntx, 16);
      chk(32'(link.mac_id), 32'(mac_id));
   endtask
   task automatic s_limit();
      int t0;
      lane <= 5'h1c;
      t0 = cyc;
      pkt(40);
      chk(32'(cyc - t0 >= 46), 1);
      chk(32'(cyc - t0 <= 70), 1);
      repeat (4) @(posedge clk_in);
   endtask
   task automatic s_store();
      int n0;
      do_reset(2'h2);
      mode <= 1'b1;
      n0 = ntx;
      send(1'b1, 1'b0);
      src_v <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(ntx, n0);
      send(1'b0, 1'b1);
      src_v <= 1'b0;
      repeat (8) @(posedge clk_in);
      chk(ntx, n0 + 2);
      mtx_rdy <= 1'b0;
      pkt(8);
      repeat (3) @(posedge clk_in);
      chk(32'(link.tx_ready), 0);
      mtx_rdy <= 1'b1;
      repeat (20) @(posedge clk_in);
      chk(ntx, n0 + 10);
   endtask
   task automatic s_rx();
      int n;
      do_reset(2'h0);
      n = 0;
      while (link.rx_ready === 1'b1 && n < 8) begin
         rxpkt(n, 1);
         mrx_v <= 1'b0;
         repeat (3) @(posedge clk_in);
         n++;
      end
      chk(32'(n >= 4 && n <= 6), 1);
      // a start met with no room is dropped whole; none of it may arrive
      rxpkt(100, 2);
      mrx_v <= 1'b0;
      snk_rdy <= 1'b1;
      repeat (12) @(posedge clk_in);
      chk(nrx, n);
      nrx = 0;
      rx_len = 4;
      rxpkt(0, 4);
      rxpkt(4, 4);
      mrx_v <= 1'b0;
      repeat (12) @(posedge clk_in);
      chk(nrx, 8);
   endtask
   initial begin
      do_reset(2'h0);
      s_lanes();
      s_limit();
      s_store();
      s_rx();
      wrap_up();
   end
endmodule // tb_top
